// ==== verification/control_source_model.sv ====
`timescale 1ns/10ps
`default_nettype none
// sequencer and test-set side: one constant pulse at a time, test word
module control_source_model (
   // requests from the bench
   input  wire logic [2:0]  pulse_sel,
   input  wire logic        pulse_go,
   input  wire logic [15:0] test_word,
   input  wire logic        test_go,
   // pulses toward the bus
   output logic             bank_address_constant_pulse,
   output logic             save_address_constant_pulse,
   output logic             minus_one_constant_pulse,
   output logic             plus_one_constant_pulse,
   output logic             plus_two_constant_pulse,
   output logic             start_address_pulse,
   // test set word, zero when the set is idle
   output logic [15:0]      test_data_input
);
   // one-hot pulse decode, held while the bench holds go
   assign bank_address_constant_pulse = pulse_go && (pulse_sel == 3'h0);
   assign save_address_constant_pulse = pulse_go && (pulse_sel == 3'h1);
   assign minus_one_constant_pulse    = pulse_go && (pulse_sel == 3'h2);
   assign plus_one_constant_pulse     = pulse_go && (pulse_sel == 3'h3);
   assign plus_two_constant_pulse     = pulse_go && (pulse_sel == 3'h4);
   assign start_address_pulse         = pulse_go && (pulse_sel == 3'h5);
   // full word, one input per bit
   assign test_data_input = test_go ? test_word : 16'h0000;
endmodule
`default_nettype wire

// ==== verification/tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none
module tb_top import wl_bus_pkg::*; ;
   logic                 ref_clk, nrst;
   logic [15:0]          reg_source_data [REG_SRC_N];
   logic [REG_SRC_N-1:0] reg_source_read;
   logic [5:0]           counter_addr_input;
   logic                 vector_addr_high_input;
   logic [3:0]           vector_addr_low_input;
   logic                 bank_address_constant_pulse, save_address_constant_pulse, minus_one_constant_pulse;
   logic                 plus_one_constant_pulse, plus_two_constant_pulse, start_address_pulse;
   logic [15:0]          channel_data_input, test_data_input, adder_sum, test_word;
   logic [8:0]           chan_addr;
   logic                 chan_read, chan_write, bank_read_pulse, bank_write_pulse, bank_clear_pulse;
   logic                 sum_write_pulse, sum_complement, address_write_pulse, write_timing_pulse;
   logic [2:0]           pulse_sel;
   logic                 pulse_go, test_go, fixed_bank_read_strobe, bank_top_bit_to_line15, fixed_access;
   logic [15:0]          write_line_bit, write_line_bit_n;
   logic [4:0]           fixed_bank_bit_out;
   logic [2:0]           erasable_bank_bit_out, bank_extension_bit_out, combined_bank_bit;
   logic [11:0]          memory_address;
   logic [7:0]           xb_sel, xt_sel, yt_sel, fixed_bank_num;
   logic [3:0]           yb_sel;
   int                   mismatches, total_checks;
   // design and far-side model
   write_line_bus dut (.ref_clk, .nrst, .reg_source_data, .reg_source_read, .counter_addr_input,
      .vector_addr_high_input, .vector_addr_low_input, .bank_address_constant_pulse,
      .save_address_constant_pulse, .minus_one_constant_pulse, .plus_one_constant_pulse,
      .plus_two_constant_pulse, .start_address_pulse, .channel_data_input, .chan_addr, .chan_read,
      .chan_write, .test_data_input, .bank_read_pulse, .bank_write_pulse, .bank_clear_pulse,
      .sum_write_pulse, .sum_complement, .adder_sum, .address_write_pulse, .write_timing_pulse,
      .write_line_bit, .write_line_bit_n, .fixed_bank_read_strobe, .bank_top_bit_to_line15,
      .fixed_bank_bit_out, .erasable_bank_bit_out, .bank_extension_bit_out, .combined_bank_bit,
      .memory_address, .xb_sel, .xt_sel, .yb_sel, .yt_sel, .fixed_bank_num, .fixed_access);
   control_source_model model (.pulse_sel, .pulse_go, .test_word, .test_go, .bank_address_constant_pulse,
      .save_address_constant_pulse, .minus_one_constant_pulse, .plus_one_constant_pulse,
      .plus_two_constant_pulse, .start_address_pulse, .test_data_input);
   // clock
   initial begin
      ref_clk = 1'b0;
      forever #10 ref_clk = ~ref_clk;
   end
   task automatic report_and_stop;
      if (mismatches == 0 && total_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED %0t word got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_small(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED %0t field got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic tick;
      @(posedge ref_clk);
      #1;
   endtask
   task automatic bus_is(input logic [15:0] exp);
      @(negedge ref_clk);
      chk_word(write_line_bit, exp);
      chk_word(write_line_bit_n, ~exp);
      tick();
   endtask
   task automatic clear_all;
      foreach (reg_source_data[i]) reg_source_data[i] = 16'h0000;
      {reg_source_read, counter_addr_input, vector_addr_high_input, vector_addr_low_input} = '0;
      {channel_data_input, chan_addr, chan_read, chan_write, adder_sum, test_word, test_go} = '0;
      {bank_read_pulse, bank_write_pulse, bank_clear_pulse, sum_write_pulse, sum_complement} = '0;
      {address_write_pulse, write_timing_pulse, pulse_sel, pulse_go} = '0;
      tick();
   endtask
   // word on the bus through the test set, then one edge with the given strobes
   task automatic edge_op(input logic [15:0] w, input logic [4:0] s, input logic [8:0] ca);
      test_word = w;
      test_go = 1'b1;
      chan_addr = ca;
      {address_write_pulse, write_timing_pulse, bank_write_pulse, bank_clear_pulse, chan_write} = s;
      tick();
      clear_all();
   endtask
   task automatic set_addr(input logic [11:0] a);
      edge_op({4'h0, a}, 5'b11000, 9'h000);
   endtask
   task automatic t_consts;
      logic [15:0] exp [6];
      exp = '{16'h0006, 16'h000d, 16'hfffe, 16'h0001, 16'h0002, 16'h0800};
      bus_is(16'h0000);
      pulse_go = 1'b1;
      for (int i = 0; i < 6; i++) begin
         pulse_sel = 3'(i);
         bus_is(exp[i]);
      end
      pulse_go = 1'b0;
      counter_addr_input = 6'h3f;
      bus_is(16'h003f);
      counter_addr_input = 6'h00;
      vector_addr_high_input = 1'b1;
      for (int k = 1; k <= 10; k++) begin
         vector_addr_low_input = 4'(k);
         bus_is(16'h0800 | 16'(k << 2));
      end
      clear_all();
   endtask
   task automatic t_sources;
      reg_source_data[0] = 16'h1234;
      reg_source_data[1] = 16'h8001;
      reg_source_data[2] = 16'hffff;
      reg_source_read = 4'b0011;
      bus_is(16'h9235);
      clear_all();
      test_word = 16'ha5a5;
      test_go = 1'b1;
      bus_is(16'ha5a5);
      clear_all();
      channel_data_input = 16'h8000;
      bus_is(16'hc000);
      channel_data_input = 16'h4000;
      bus_is(16'h0000);
      clear_all();
   endtask
   task automatic t_addr;
      edge_op(16'h00c9, 5'b10000, 9'h000);
      chk_word({4'h0, memory_address}, 16'h0000);
      edge_op(16'h00c9, 5'b01000, 9'h000);
      chk_word({4'h0, memory_address}, 16'h0000);
      set_addr(12'h0c9);
      chk_word({4'h0, memory_address}, 16'h00c9);
      bus_is(16'h0000);
      chk_small(xb_sel, 8'h02);
      chk_small(xt_sel, 8'h02);
      chk_small({4'h0, yb_sel}, 8'h08);
      chk_small(yt_sel, 8'h01);
   endtask
   task automatic t_banks;
      set_addr(12'h004);
      edge_op(16'h8400, 5'b00100, 9'h000);
      chk_small({3'h0, fixed_bank_bit_out}, 8'h11);
      bank_read_pulse = 1'b1;
      bus_is(16'hc400);
      chk_small({6'h0, fixed_bank_read_strobe, bank_top_bit_to_line15}, 8'h03);
      clear_all();
      edge_op(16'h8400, 5'b00110, 9'h000);
      chk_small({3'h0, fixed_bank_bit_out}, 8'h00);
      adder_sum = 16'hc3ff;
      sum_complement = 1'b1;
      sum_write_pulse = 1'b1;
      tick();
      clear_all();
      chk_small({3'h0, fixed_bank_bit_out}, 8'h0f);
      set_addr(12'h003);
      edge_op(16'h0700, 5'b00100, 9'h000);
      chk_small({5'h0, erasable_bank_bit_out}, 8'h07);
      bank_read_pulse = 1'b1;
      bus_is(16'h0300);
      chk_small({7'h0, fixed_bank_read_strobe}, 8'h00);
      clear_all();
      set_addr(12'h005);
      edge_op(16'h0000, 5'b00100, 9'h000);
      chk_small({fixed_bank_bit_out, erasable_bank_bit_out}, 8'h7f);
      set_addr(12'h006);
      bank_read_pulse = 1'b1;
      bus_is(16'h3f07);
      chk_small({4'h0, fixed_bank_read_strobe, combined_bank_bit}, 8'h0f);
      clear_all();
   endtask
   task automatic t_ext_fixed;
      // write channel 7, read it back in the very next cycle
      test_word = 16'h0050;
      test_go = 1'b1;
      chan_addr = 9'h007;
      chan_write = 1'b1;
      tick();
      {test_go, chan_write, chan_read} = 3'b001;
      bus_is(16'h0050);
      clear_all();
      chk_small({5'h0, bank_extension_bit_out}, 8'h05);
      edge_op(16'h0070, 5'b00001, 9'h006);
      chk_small({5'h0, bank_extension_bit_out}, 8'h05);
      chan_addr = 9'h007;
      chan_read = 1'b1;
      bus_is(16'h0050);
      clear_all();
      set_addr(12'h004);
      edge_op(16'hbc00, 5'b00100, 9'h000);
      set_addr(12'h400);
      chk_small(fixed_bank_num, 8'hbf);
      chk_small({7'h0, fixed_access}, 8'h01);
      set_addr(12'h800);
      chk_small(fixed_bank_num, 8'h02);
   endtask
   // watchdog, far beyond the roughly 80 cycles the tests need
   initial begin
      #200000;
      mismatches++;
      report_and_stop();
   end
   // main sequence
   initial begin
      mismatches = 0;
      total_checks = 0;
      nrst = 1'b0;
      clear_all();
      repeat (7) @(posedge ref_clk);
      #1;
      nrst = 1'b1;
      tick();
      t_consts();
      t_sources();
      t_addr();
      t_banks();
      t_ext_fixed();
      report_and_stop();
   end
endmodule
`default_nettype wire

// ==== verilog/addr_decoder.sv ====
`timescale 1ns/10ps
`default_nettype none
module addr_decoder
   import wl_bus_pkg::*;
(
   // address state in, selections out
   addr_link_if.dec lnk
);
   logic [2:0] yt_index;
   logic [4:0] bank_low;

   // switched segment takes its Y-top group from the erasable bank
   always_comb begin
      if (lnk.mem_addr[9:8] == SWITCHED_SEG) begin
         yt_index = lnk.erasable_bank_select; // RULE20
      end else begin
         yt_index = {1'b0, lnk.mem_addr[9:8]}; // RULE20
      end
   end

   // one-hot X and Y selections, 8x8 X and 4x8 Y
   always_comb begin
      lnk.xb_sel = 8'h00;
      lnk.xt_sel = 8'h00;
      lnk.yb_sel = 4'h0;
      lnk.yt_sel = 8'h00;
      lnk.xb_sel[lnk.mem_addr[2:0]] = 1'b1; // RULE21
      lnk.xt_sel[lnk.mem_addr[5:3]] = 1'b1; // RULE21
      lnk.yb_sel[lnk.mem_addr[7:6]] = 1'b1; // RULE21
      lnk.yt_sel[yt_index] = 1'b1; // RULE21
   end

   // fixed bank number from address bits 12-11, bank and extension
   always_comb begin
      lnk.fixed_access = (lnk.mem_addr[11:10] != 2'h0);
      if (lnk.mem_addr[11:10] == FIXED_SEG) begin
         bank_low = lnk.fixed_bank_select; // RULE5
      end else begin
         bank_low = {3'h0, lnk.mem_addr[11:10]}; // RULE5
      end
      if (lnk.mem_addr[11:10] == FIXED_SEG && lnk.fixed_bank_select[4:3] == SUPER_BANKS) begin
         lnk.fixed_bank_num = {lnk.fixed_bank_extension, bank_low}; // RULE5
      end else begin
         lnk.fixed_bank_num = {3'h0, bank_low};
      end
   end
endmodule
`default_nettype wire

// ==== verilog/addr_link_if.sv ====
`timescale 1ns/10ps
`default_nettype none
// address state passed to the decoder and its selections back
interface addr_link_if;
   logic [11:0] mem_addr;
   logic [2:0]  erasable_bank_select;
   logic [4:0]  fixed_bank_select;
   logic [2:0]  fixed_bank_extension;
   logic [7:0]  xb_sel;
   logic [7:0]  xt_sel;
   logic [3:0]  yb_sel;
   logic [7:0]  yt_sel;
   logic [7:0]  fixed_bank_num;
   logic        fixed_access;
   modport src (output mem_addr, erasable_bank_select, fixed_bank_select, fixed_bank_extension,
                input  xb_sel, xt_sel, yb_sel, yt_sel, fixed_bank_num, fixed_access);
   modport dec (input  mem_addr, erasable_bank_select, fixed_bank_select, fixed_bank_extension,
                output xb_sel, xt_sel, yb_sel, yt_sel, fixed_bank_num, fixed_access);
endinterface
`default_nettype wire

// ==== verilog/wl_bus_pkg.sv ====
// Notes on behaviour
// [RULE1] fixed bank loads from adder sum, direct or complemented, or write lines 11-14,16.
// [RULE2] one fixed-bank read strobe whenever fixed bank is read, alone or with erasable bank.
// [RULE3] fixed bank readout puts bits 11-14,16 on their lines, bit 16 also on 15.
// [RULE4] bank extension is channel 0007, word bits 5, 6 and 7.
// [RULE5] fixed address built from extension, fixed bank, address bits 11-12 and decoder.
// [RULE6] every write line is the OR of its sources; complement output is its inverse.
// [RULE7] one line per bit; each register output bit feeds the line of same position.
// [RULE8] counter address inputs drive only the six low lines, up to 0077 octal.
// [RULE9] vector inputs set line 12 and index on lines 6..3: 4004 to 4050 octal.
// [RULE10] both banks read: bank bits on lines 1-3; lone erasable 9-10; lone fixed 11-16.
// [RULE11] bank-address pulse puts 00006 on the lines, selecting both banks.
// [RULE12] save-address pulse puts octal 00015 on the lines.
// [RULE13] minus-one pulse drives lines 2-16, not line 1: octal 177776.
// [RULE14] plus-one pulse gives 000001, plus-two pulse gives 000002 octal.
// [RULE15] start-address pulse drives only line 12: octal 04000.
// [RULE16] channel input bits go onto lines 1-14 and 16.
// [RULE17] test set can drive a full 16-bit word, one input per bit.
// [RULE18] address register loads 12 bits only when address-write and write-timing coincide.
// [RULE19] address register has no readout onto the write lines.
// [RULE20] address alone selects first 768 erasable words; bank bits select the rest.
// [RULE21] erasable selection is X-Y with 64 X lines and 32 Y lines.
// [RULE22] address 0003 services the erasable bank, 0004 the fixed bank.
// [RULE23] sources are combinational in their pulse; idle bus reads zero.
package wl_bus_pkg;
   localparam int          WORD_W        = 16;
   localparam int          ADDR_W        = 12;
   localparam int          REG_SRC_N     = 4;
   localparam int          CHAN_ADDR_W   = 9;
   // bank service addresses
   localparam logic [11:0] ADDR_ERASABLE_BANK_SELECT    = 12'h003;
   localparam logic [11:0] ADDR_FIXED_BANK_SELECT    = 12'h004;
   localparam logic [11:0] ADDR_BOTH     = 12'h006;
   localparam logic [8:0]  CHAN_FIXED_BANK_EXTENSION     = 9'h007;
   // field positions in the word (bit index = line - 1)
   localparam int          EB_LSB        = 8;
   localparam int          FB_LSB        = 10;
   localparam int          FB_TOP        = 15;
   localparam int          FIXED_BANK_EXTENSION_LSB      = 4;
   localparam int          BBK_LSB       = 0;
   localparam int          VEC_LSB       = 2;
   localparam int          VEC_HIGH      = 11;
   // reset values
   localparam logic [2:0]  ERASABLE_BANK_SELECT_RST     = 3'h0;
   localparam logic [4:0]  FIXED_BANK_SELECT_RST     = 5'h00;
   localparam logic [2:0]  FIXED_BANK_EXTENSION_RST      = 3'h0;
   localparam logic [11:0] MADDR_RST     = 12'h000;
   // constant pulse words
   localparam logic [15:0] K_BANK_ADDR   = 16'h0006;
   localparam logic [15:0] K_SAVE_ADDR   = 16'h000d;
   localparam logic [15:0] K_MINUS_ONE   = 16'hfffe;
   localparam logic [15:0] K_PLUS_ONE    = 16'h0001;
   localparam logic [15:0] K_PLUS_TWO    = 16'h0002;
   localparam logic [15:0] K_START_ADDR  = 16'h0800;
   localparam logic [15:0] CHAN_MASK     = 16'hbfff;
   // decoder geometry
   localparam logic [1:0]  SWITCHED_SEG  = 2'h3;
   localparam logic [1:0]  FIXED_SEG     = 2'h1;
   localparam logic [1:0]  SUPER_BANKS   = 2'h3;
endpackage

// ==== verilog/write_line_bus.sv ====
`timescale 1ns/10ps
`default_nettype none
module write_line_bus
   import wl_bus_pkg::*;
(
   // clock and reset
   input  wire logic                 ref_clk,
   input  wire logic                 nrst,
   // flip-flop register sources
   input  wire logic [15:0]          reg_source_data [REG_SRC_N],
   input  wire logic [REG_SRC_N-1:0] reg_source_read,
   // priority control sources
   input  wire logic [5:0]           counter_addr_input,
   input  wire logic                 vector_addr_high_input,
   input  wire logic [3:0]           vector_addr_low_input,
   // constant pulses
   input  wire logic                 bank_address_constant_pulse,
   input  wire logic                 save_address_constant_pulse,
   input  wire logic                 minus_one_constant_pulse,
   input  wire logic                 plus_one_constant_pulse,
   input  wire logic                 plus_two_constant_pulse,
   input  wire logic                 start_address_pulse,
   // channel and test set
   input  wire logic [15:0]          channel_data_input,
   input  wire logic [8:0]           chan_addr,
   input  wire logic                 chan_read,
   input  wire logic                 chan_write,
   input  wire logic [15:0]          test_data_input,
   // bank service and adder
   input  wire logic                 bank_read_pulse,
   input  wire logic                 bank_write_pulse,
   input  wire logic                 bank_clear_pulse,
   input  wire logic                 sum_write_pulse,
   input  wire logic                 sum_complement,
   input  wire logic [15:0]          adder_sum,
   // address register load
   input  wire logic                 address_write_pulse,
   input  wire logic                 write_timing_pulse,
   // bus and strobes
   output logic [15:0]               write_line_bit,
   output logic [15:0]               write_line_bit_n,
   output logic                      fixed_bank_read_strobe,
   output logic                      bank_top_bit_to_line15,
   // bank outputs
   output logic [4:0]                fixed_bank_bit_out,
   output logic [2:0]                erasable_bank_bit_out,
   output logic [2:0]                bank_extension_bit_out,
   output logic [2:0]                combined_bank_bit,
   // memory address selection
   output logic [11:0]               memory_address,
   output logic [7:0]                xb_sel,
   output logic [7:0]                xt_sel,
   output logic [3:0]                yb_sel,
   output logic [7:0]                yt_sel,
   output logic [7:0]                fixed_bank_num,
   output logic                      fixed_access
);
   logic [2:0]  erasable_bank_select_reg;
   logic [4:0]  fixed_bank_select_reg;
   logic [2:0]  fixed_bank_extension_reg;
   logic [11:0] memory_address_reg;
   logic        sel_eb;
   logic        sel_fb;
   logic        sel_both;
   logic        read_eb_only;
   logic        read_fb_only;
   logic        read_both;
   logic        fixed_bank_extension_hit;
   logic        address_load_gate;
   logic [15:0] reg_or;
   logic [15:0] bank_word;
   logic [15:0] const_word;
   logic [15:0] prio_word;
   logic [15:0] chan_word;
   logic [15:0] bus_word;
   logic [15:0] load_word;
   logic [4:0]  fixed_bank_select_next;
   logic [2:0]  erasable_bank_select_next;
   logic        any_source;

   addr_link_if lnk ();

   // service decode from the address register
   assign sel_eb       = (memory_address_reg == ADDR_ERASABLE_BANK_SELECT); // RULE22
   assign sel_fb       = (memory_address_reg == ADDR_FIXED_BANK_SELECT); // RULE22
   assign sel_both     = (memory_address_reg == ADDR_BOTH); // RULE11
   assign read_eb_only = bank_read_pulse && sel_eb;
   assign read_fb_only = bank_read_pulse && sel_fb;
   assign read_both    = bank_read_pulse && sel_both;
   assign fixed_bank_read_strobe = read_fb_only || read_both; // RULE2
   assign fixed_bank_extension_hit     = (chan_addr == CHAN_FIXED_BANK_EXTENSION); // RULE4
   assign address_load_gate = address_write_pulse && write_timing_pulse; // RULE18

   // register outputs, one OR column per bit position
   genvar b;
   generate
      for (b = 0; b < WORD_W; b++) begin : g_col
         logic [REG_SRC_N-1:0] col;
         for (genvar s = 0; s < REG_SRC_N; s++) begin : g_src
            assign col[s] = reg_source_read[s] & reg_source_data[s][b]; // RULE7
         end
         assign reg_or[b] = |col; // RULE6
      end
   endgenerate

   // bank readout onto the lines
   always_comb begin
      bank_word = 16'h0000;
      if (read_eb_only || read_both) begin
         bank_word[EB_LSB +: 2] = erasable_bank_select_reg[1:0]; // RULE10
      end
      if (read_both) begin
         bank_word[BBK_LSB +: 3] = combined_bank_bit; // RULE10
      end
      if (fixed_bank_read_strobe) begin
         bank_word[FB_LSB +: 4] = fixed_bank_select_reg[3:0]; // RULE3
         bank_word[FB_TOP]      = fixed_bank_select_reg[4]; // RULE3
         bank_word[FB_TOP-1]    = bank_top_bit_to_line15; // RULE3
      end
      if (chan_read && fixed_bank_extension_hit) begin
         bank_word[FIXED_BANK_EXTENSION_LSB +: 3] = fixed_bank_extension_reg; // RULE4
      end
   end
   assign combined_bank_bit      = erasable_bank_select_reg; // RULE10
   assign bank_top_bit_to_line15 = fixed_bank_select_reg[4] & fixed_bank_read_strobe; // RULE3

   // constant generating pulses
   always_comb begin
      const_word = 16'h0000;
      if (bank_address_constant_pulse) begin
         const_word = const_word | K_BANK_ADDR; // RULE11
      end
      if (save_address_constant_pulse) begin
         const_word = const_word | K_SAVE_ADDR; // RULE12
      end
      if (minus_one_constant_pulse) begin
         const_word = const_word | K_MINUS_ONE; // RULE13
      end
      if (plus_one_constant_pulse) begin
         const_word = const_word | K_PLUS_ONE; // RULE14
      end
      if (plus_two_constant_pulse) begin
         const_word = const_word | K_PLUS_TWO; // RULE14
      end
      if (start_address_pulse) begin
         const_word = const_word | K_START_ADDR; // RULE15
      end
   end

   // counter and interrupt vector addresses
   always_comb begin
      prio_word = {10'h000, counter_addr_input}; // RULE8
      prio_word[VEC_HIGH] = vector_addr_high_input; // RULE9
      prio_word[VEC_LSB +: 4] = prio_word[VEC_LSB +: 4] | vector_addr_low_input; // RULE9
   end

   // channel bit 16 also feeds line 15, channel bit 15 has no path
   always_comb begin
      chan_word = channel_data_input & CHAN_MASK; // RULE16
      chan_word[14] = channel_data_input[15]; // RULE16
   end

   // wired-or bus, zero when idle
   assign bus_word = reg_or | bank_word | const_word | prio_word | chan_word
                   | test_data_input; // RULE6 RULE17 RULE19 RULE23
   assign write_line_bit   = bus_word; // RULE6
   assign write_line_bit_n = ~bus_word; // RULE6
   assign any_source = (|reg_source_read) || bank_read_pulse || (chan_read && fixed_bank_extension_hit)
                     || bank_address_constant_pulse || save_address_constant_pulse
                     || minus_one_constant_pulse || plus_one_constant_pulse
                     || plus_two_constant_pulse || start_address_pulse
                     || (|counter_addr_input) || vector_addr_high_input
                     || (|vector_addr_low_input) || (|channel_data_input)
                     || (|test_data_input);

   // bank load word: adder sum direct or complemented, else the lines
   always_comb begin
      if (sum_write_pulse) begin
         load_word = sum_complement ? ~adder_sum : adder_sum; // RULE1
      end else begin
         load_word = bus_word; // RULE1
      end
      fixed_bank_select_next = {load_word[FB_TOP], load_word[FB_LSB +: 4]}; // RULE1
      if (sel_both) begin
         erasable_bank_select_next = load_word[BBK_LSB +: 3];
      end else begin
         erasable_bank_select_next = load_word[EB_LSB +: 3];
      end
   end

   // fixed bank register
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         fixed_bank_select_reg <= FIXED_BANK_SELECT_RST;
      end else if (bank_clear_pulse && (sel_fb || sel_both)) begin
         fixed_bank_select_reg <= FIXED_BANK_SELECT_RST;
      end else if ((bank_write_pulse || sum_write_pulse) && (sel_fb || sel_both)) begin
         fixed_bank_select_reg <= fixed_bank_select_next; // RULE1
      end
   end

   // erasable bank register
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         erasable_bank_select_reg <= ERASABLE_BANK_SELECT_RST;
      end else if (bank_clear_pulse && (sel_eb || sel_both)) begin
         erasable_bank_select_reg <= ERASABLE_BANK_SELECT_RST;
      end else if ((bank_write_pulse || sum_write_pulse) && (sel_eb || sel_both)) begin
         erasable_bank_select_reg <= erasable_bank_select_next; // RULE22
      end
   end

   // bank extension, written as input/output channel 7
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         fixed_bank_extension_reg <= FIXED_BANK_EXTENSION_RST;
      end else if (chan_write && fixed_bank_extension_hit) begin
         fixed_bank_extension_reg <= bus_word[FIXED_BANK_EXTENSION_LSB +: 3]; // RULE4
      end
   end

   // memory address register, write only
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         memory_address_reg <= MADDR_RST;
      end else if (address_load_gate) begin
         memory_address_reg <= bus_word[ADDR_W-1:0]; // RULE18
      end
   end

   // decoder hookup
   assign lnk.mem_addr = memory_address_reg;
   assign lnk.erasable_bank_select    = erasable_bank_select_reg;
   assign lnk.fixed_bank_select    = fixed_bank_select_reg;
   assign lnk.fixed_bank_extension     = fixed_bank_extension_reg;

   addr_decoder u_dec (
      .lnk (lnk.dec)
   );

   // outputs
   assign fixed_bank_bit_out     = fixed_bank_select_reg;
   assign erasable_bank_bit_out  = erasable_bank_select_reg;
   assign bank_extension_bit_out = fixed_bank_extension_reg;
   assign memory_address         = memory_address_reg;
   assign xb_sel                 = lnk.xb_sel;
   assign xt_sel                 = lnk.xt_sel;
   assign yb_sel                 = lnk.yb_sel;
   assign yt_sel                 = lnk.yt_sel;
   assign fixed_bank_num         = lnk.fixed_bank_num; // RULE5
   assign fixed_access           = lnk.fixed_access;

   // checks
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!nrst);

   fixed_bank_select_load_a: assert property (bank_write_pulse && !sum_write_pulse && !bank_clear_pulse && sel_fb // RULE1
      |=> fixed_bank_select_reg == {$past(bus_word[15]), $past(bus_word[13:10])})
      else $error("fixed bank did not load from lines");
   fb_strobe_a: assert property (fixed_bank_read_strobe == (bank_read_pulse && (sel_fb || sel_both))) // RULE2
      else $error("fixed bank read strobe wrong");
   fb_line15_a: assert property (read_fb_only |-> write_line_bit[14] >= fixed_bank_select_reg[4]) // RULE3
      else $error("bank bit 16 missing on line 15");
   fixed_bank_extension_write_a: assert property (chan_write && fixed_bank_extension_hit ##1 chan_read && fixed_bank_extension_hit // RULE4
      |-> (write_line_bit[6:4] & $past(bus_word[6:4])) == $past(bus_word[6:4]))
      else $error("bank extension readback wrong");
   minus_one_a: assert property (minus_one_constant_pulse |-> write_line_bit[15:1] == 15'h7fff) // RULE13
      else $error("minus one not on lines");
   saddr_load_a: assert property (address_load_gate |=> memory_address_reg == $past(bus_word[11:0])) // RULE18
      else $error("address register missed load");
   saddr_hold_a: assert property (!address_load_gate |=> $stable(memory_address_reg)) // RULE18
      else $error("address register changed without gate");
   idle_bus_a: assert property (!any_source |-> write_line_bit == 16'h0000 // RULE23
      && write_line_bit_n == 16'hffff)
      else $error("idle bus not zero");
   counter_only_a: assert property (!any_source ##0 1'b1 or (|counter_addr_input) && !(any_source && // RULE8
      ((|reg_source_read) || bank_read_pulse || chan_read || (|channel_data_input) || (|test_data_input)
      || vector_addr_high_input || (|vector_addr_low_input) || (|const_word)))
      |-> write_line_bit[15:6] == 10'h000)
      else $error("counter address reached high lines");
   start_addr_a: assert property (start_address_pulse && !(any_source && ((|reg_source_read)
      || bank_read_pulse || (|prio_word) || (|chan_word) || (|test_data_input)
      || (|(const_word & ~K_START_ADDR)))) |-> write_line_bit == K_START_ADDR) // RULE15
      else $error("start address wrong");

   both_read_c: cover property (read_both);
   fixed_bank_extension_c: cover property (chan_write && fixed_bank_extension_hit ##1 chan_read && fixed_bank_extension_hit);
   saddr_c: cover property (address_load_gate ##1 fixed_access);
endmodule
`default_nettype wire
